// ### hdl/iofc_pkg.sv
package iofc_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses (lower byte; upper byte is address + 1)
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_SUPPLY     = 7'h02;
   localparam logic [6:0] ADDR_RATE       = 7'h04;
   localparam logic [6:0] ADDR_ACCEL_X    = 7'h0a;
   localparam logic [6:0] ADDR_ACCEL_Y    = 7'h0c;
   localparam logic [6:0] ADDR_ACCEL_Z    = 7'h0e;
   localparam logic [6:0] ADDR_TEMP       = 7'h10;
   localparam logic [6:0] ADDR_PITCH      = 7'h12;
   localparam logic [6:0] ADDR_ROLL       = 7'h14;
   localparam logic [6:0] ADDR_AUX        = 7'h16;
   localparam logic [6:0] ADDR_RATE_TRIM  = 7'h1a;
   localparam logic [6:0] ADDR_PITCH_ALGN = 7'h1c;
   localparam logic [6:0] ADDR_ROLL_ALGN  = 7'h1e;
   localparam logic [6:0] ADDR_ACCX_TRIM  = 7'h20;
   localparam logic [6:0] ADDR_ACCY_TRIM  = 7'h22;
   localparam logic [6:0] ADDR_ACCZ_TRIM  = 7'h24;
   localparam logic [6:0] ADDR_RANGE      = 7'h38;
   localparam logic [6:0] ADDR_DIAG       = 7'h3c;
   localparam logic [6:0] ADDR_COMMAND    = 7'h3e;

   // ----------------------------------------------------------------
   // Frame and field layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS   = 16;
   localparam int FRAME_WR_BIT = 15;
   localparam int FLAG_ND_BIT  = 15;
   localparam int FLAG_EA_BIT  = 14;
   localparam int CMD_NULL_BIT = 0;
   localparam int CMD_PREC_BIT = 4;
   localparam int NUM_OUTPUTS  = 9;

   localparam logic [15:0] RATE_TRIM_MASK  = 16'h1fff;
   localparam logic [15:0] ACCEL_TRIM_MASK = 16'h0fff;
   localparam logic [15:0] ALIGN_MASK      = 16'h03ff;
   localparam logic [15:0] TRIM_RESET      = 16'h0000;

   // Range select codes, upper byte bits [2:0]
   localparam logic [2:0] RANGE_WIDE   = 3'h4;
   localparam logic [2:0] RANGE_MIDDLE = 3'h2;
   localparam logic [2:0] RANGE_NARROW = 3'h1;

   // Saturation limits
   localparam logic signed [17:0] MAX14 = 18'sh01fff;
   localparam logic signed [17:0] MIN14 = -18'sh02000;
   localparam logic signed [17:0] MAX13 = 18'sh00fff;
   localparam logic signed [17:0] MIN13 = -18'sh01000;
   localparam int AVG_SHIFT = 4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 20_000_000;
   localparam int NV_SAVE_MS    = 50;
   localparam int PREC_NULL_SEC = 30;
   localparam int NV_SAVE_CYC   = NV_SAVE_MS * (CLK_HZ / 1000);
   localparam int PREC_NULL_CYC = PREC_NULL_SEC * CLK_HZ;

   typedef enum logic [3:0] {
      ST_RUN  = 4'h1,
      ST_NULL = 4'h2,
      ST_PREC = 4'h4,
      ST_SAVE = 4'h8
   } iofc_state_e;

endpackage

// ### hdl/iofc_frame_if.sv
`timescale 1ns/1ns
interface iofc_frame_if;
   logic        frame_valid;
   logic [15:0] frame_word;
   logic [15:0] tx_word;
   modport port (output frame_valid, output frame_word, input tx_word);
   modport core (input frame_valid, input frame_word, output tx_word);
endinterface

// ### hdl/iofc_spi_port.sv
`timescale 1ns/1ns
module iofc_spi_port (
   // Clock and reset
   input  wire logic     mclk,
   input  wire logic     rst,
   input  wire logic     ce,
   // Serial pins
   input  wire logic     cs_n,
   input  wire logic     sclk,
   input  wire logic     din,
   output logic          dout,
   // Frame side
   iofc_frame_if.port    fr
);
   logic        sclk_reg,  sclk_next;
   logic [15:0] rx_reg,    rx_next;
   logic [15:0] tx_reg,    tx_next;
   logic [4:0]  cnt_reg,   cnt_next;
   logic        dout_reg,  dout_next;
   logic        valid_reg, valid_next;
   logic [15:0] word_reg,  word_next;

   // Sclk idles high: sample on rise, shift out on fall
   always_comb begin
      sclk_next  = sclk;
      rx_next    = rx_reg;
      tx_next    = tx_reg;
      cnt_next   = cnt_reg;
      dout_next  = dout_reg;
      valid_next = 1'b0;
      word_next  = word_reg;
      if (cs_n) begin
         // Reload between frames so the answer is ready at select
         cnt_next  = 5'h00;
         tx_next   = fr.tx_word;
         dout_next = fr.tx_word[iofc_pkg::FRAME_BITS-1];
      end else if (sclk && !sclk_reg) begin
         rx_next = {rx_reg[14:0], din};
         if (cnt_reg == 5'(iofc_pkg::FRAME_BITS - 1)) begin
            cnt_next   = 5'h00;
            valid_next = 1'b1;
            word_next  = {rx_reg[14:0], din};
         end else begin
            cnt_next = cnt_reg + 5'h01;
         end
      end else if (!sclk && sclk_reg && cnt_reg != 5'h00) begin
         // First fall keeps the preloaded MSB for the first rise
         tx_next   = {tx_reg[14:0], 1'b0};
         dout_next = tx_reg[iofc_pkg::FRAME_BITS-2];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_reg  <= 1'b1;
         rx_reg    <= 16'h0000;
         tx_reg    <= 16'h0000;
         cnt_reg   <= 5'h00;
         dout_reg  <= 1'b0;
         valid_reg <= 1'b0;
         word_reg  <= 16'h0000;
      end else if (ce) begin
         sclk_reg  <= sclk_next;
         rx_reg    <= rx_next;
         tx_reg    <= tx_next;
         cnt_reg   <= cnt_next;
         dout_reg  <= dout_next;
         valid_reg <= valid_next;
         word_reg  <= word_next;
      end
   end

   assign dout           = dout_reg;
   assign fr.frame_valid = valid_reg;
   assign fr.frame_word  = word_reg;
endmodule

// ### hdl/iofc_core.sv
`timescale 1ns/1ns
module iofc_core #(
   parameter int NV_SAVE_CYCLES   = iofc_pkg::NV_SAVE_CYC,
   parameter int PREC_NULL_CYCLES = iofc_pkg::PREC_NULL_CYC,
   parameter logic [15:0] PITCH_ALIGN_INIT = 16'h0000,
   parameter logic [15:0] ROLL_ALIGN_INIT  = 16'h0000
) (
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Serial port
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout,
   // Converter samples
   input  wire logic        sample_valid,
   input  wire logic [15:0] raw_rate,
   input  wire logic [13:0] raw_accel_x,
   input  wire logic [13:0] raw_accel_y,
   input  wire logic [13:0] raw_accel_z,
   input  wire logic [11:0] raw_supply,
   input  wire logic [11:0] raw_temp,
   input  wire logic [11:0] raw_aux,
   input  wire logic [15:0] diagnostic_status,
   // Status
   output logic             nv_save_req,
   output logic             offline
);
   iofc_frame_if fr ();

   iofc_spi_port u_spi (
      .mclk (mclk),
      .rst  (rst),
      .ce   (ce),
      .cs_n (cs_n),
      .sclk (sclk),
      .din  (din),
      .dout (dout),
      .fr   (fr.port)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [13:0] sat14(input logic signed [17:0] v);
      if (v > iofc_pkg::MAX14)
         return iofc_pkg::MAX14[13:0];
      else if (v < iofc_pkg::MIN14)
         return iofc_pkg::MIN14[13:0];
      return v[13:0];
   endfunction

   function automatic logic [12:0] sat13(input logic signed [17:0] v);
      if (v > iofc_pkg::MAX13)
         return iofc_pkg::MAX13[12:0];
      else if (v < iofc_pkg::MIN13)
         return iofc_pkg::MIN13[12:0];
      return v[12:0];
   endfunction

   // Linear tilt estimate: 1g = ~1636 counts maps to 90 deg = 2045 counts
   function automatic logic [12:0] tilt(input logic [13:0] acc, input logic [15:0] algn);
      logic signed [17:0] a;
      logic signed [17:0] c;
      a = 18'(signed'(acc));
      c = 18'(signed'(algn[9:0]));
      // Alignment 0.014 deg/count rescaled to 0.044 deg/count (x5/16)
      return sat13(a + (a >>> 2) + (c >>> 2) + (c >>> 4));
   endfunction

   // Output slot of a byte address, or NUM_OUTPUTS when none
   function automatic int slot(input logic [6:0] a);
      case ({a[6:1], 1'b0})
         iofc_pkg::ADDR_SUPPLY:  return 0;
         iofc_pkg::ADDR_RATE:    return 1;
         iofc_pkg::ADDR_ACCEL_X: return 2;
         iofc_pkg::ADDR_ACCEL_Y: return 3;
         iofc_pkg::ADDR_ACCEL_Z: return 4;
         iofc_pkg::ADDR_TEMP:    return 5;
         iofc_pkg::ADDR_PITCH:   return 6;
         iofc_pkg::ADDR_ROLL:    return 7;
         iofc_pkg::ADDR_AUX:     return 8;
         default:                return iofc_pkg::NUM_OUTPUTS;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   iofc_pkg::iofc_state_e state_reg, state_next;
   logic [13:0] out14_reg [0:3];
   logic [13:0] out14_next [0:3];
   logic [12:0] pitch_reg, pitch_next, roll_reg, roll_next;
   logic [11:0] supply_reg, supply_next, temp_reg, temp_next, aux_reg, aux_next;
   logic [8:0]  nd_reg, nd_next;
   logic [15:0] rate_trim_reg, rate_trim_next;
   logic [15:0] acc_trim_reg [0:2];
   logic [15:0] acc_trim_next [0:2];
   logic [15:0] pitch_align_reg, roll_align_reg;
   logic [2:0]  range_reg, range_next;
   logic [15:0] diag_reg;
   logic [7:0]  cmd_reg, cmd_next;
   logic [29:0] timer_reg, timer_next;
   logic signed [17:0] avg_reg, avg_next;
   logic [15:0] tx_reg, tx_next;
   logic        save_reg, save_next;
   logic        off_reg, off_next;

   logic signed [17:0] fine;
   logic [13:0] acc_res [0:2];
   logic [15:0] rdata;
   logic [6:0]  fa;
   logic [7:0]  fd;
   logic        flag_ea;
   int          rslot;

   assign fa      = fr.frame_word[14:8];
   assign fd      = fr.frame_word[7:0];
   assign flag_ea = |diag_reg;

   // Rate in the finest unit (0.0125 deg/s), trim added
   assign fine = 18'(signed'(raw_rate)) + 18'(signed'(rate_trim_reg[12:0]));

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      logic [13:0] d;
      d     = 14'h0000;
      rslot = slot(fa);
      case ({fa[6:1], 1'b0})
         iofc_pkg::ADDR_SUPPLY:     d = {2'h0, supply_reg};
         iofc_pkg::ADDR_RATE:       d = out14_reg[0];
         iofc_pkg::ADDR_ACCEL_X:    d = out14_reg[1];
         iofc_pkg::ADDR_ACCEL_Y:    d = out14_reg[2];
         iofc_pkg::ADDR_ACCEL_Z:    d = out14_reg[3];
         iofc_pkg::ADDR_TEMP:       d = {2'h0, temp_reg};
         iofc_pkg::ADDR_PITCH:      d = {1'b0, pitch_reg};
         iofc_pkg::ADDR_ROLL:       d = {1'b0, roll_reg};
         iofc_pkg::ADDR_AUX:        d = {2'h0, aux_reg};
         default:                   d = 14'h0000;
      endcase
      if (rslot < iofc_pkg::NUM_OUTPUTS)
         rdata = {nd_reg[rslot], flag_ea, d};
      else begin
         case ({fa[6:1], 1'b0})
            iofc_pkg::ADDR_RATE_TRIM:  rdata = rate_trim_reg & iofc_pkg::RATE_TRIM_MASK;
            iofc_pkg::ADDR_ACCX_TRIM:  rdata = acc_trim_reg[0] & iofc_pkg::ACCEL_TRIM_MASK;
            iofc_pkg::ADDR_ACCY_TRIM:  rdata = acc_trim_reg[1] & iofc_pkg::ACCEL_TRIM_MASK;
            iofc_pkg::ADDR_ACCZ_TRIM:  rdata = acc_trim_reg[2] & iofc_pkg::ACCEL_TRIM_MASK;
            iofc_pkg::ADDR_PITCH_ALGN: rdata = pitch_align_reg & iofc_pkg::ALIGN_MASK;
            iofc_pkg::ADDR_ROLL_ALGN:  rdata = roll_align_reg & iofc_pkg::ALIGN_MASK;
            iofc_pkg::ADDR_RANGE:      rdata = {5'h00, range_reg, 8'h00};
            iofc_pkg::ADDR_DIAG:       rdata = diag_reg;
            iofc_pkg::ADDR_COMMAND:    rdata = {8'h00, cmd_reg};
            default:                   rdata = 16'h0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic signed [17:0] rng;
      rng            = 18'sh00000;
      state_next     = state_reg;
      out14_next     = out14_reg;
      pitch_next     = pitch_reg;
      roll_next      = roll_reg;
      supply_next    = supply_reg;
      temp_next      = temp_reg;
      aux_next       = aux_reg;
      nd_next        = nd_reg;
      rate_trim_next = rate_trim_reg;
      acc_trim_next  = acc_trim_reg;
      range_next     = range_reg;
      cmd_next       = cmd_reg;
      timer_next     = timer_reg;
      avg_next       = avg_reg;
      tx_next        = tx_reg;
      save_next      = 1'b0;
      off_next       = off_reg;
      case (range_reg)
         iofc_pkg::RANGE_MIDDLE: rng = fine >>> 1;
         iofc_pkg::RANGE_NARROW: rng = fine;
         default:                rng = fine >>> 2;
      endcase
      for (int i = 0; i < 3; i++) begin
         acc_res[i] = sat14(18'(signed'(i == 0 ? raw_accel_x : (i == 1 ? raw_accel_y : raw_accel_z)))
                            + 18'(signed'(acc_trim_reg[i][11:0])));
      end

      // Host reads clear the slot flag; a new sample below still wins
      if (fr.frame_valid && !fr.frame_word[iofc_pkg::FRAME_WR_BIT]) begin
         tx_next = rdata;
         if (rslot < iofc_pkg::NUM_OUTPUTS)
            nd_next[rslot] = 1'b0;
      end

      // Byte writes, upper byte at odd address; ignored while busy
      if (fr.frame_valid && fr.frame_word[iofc_pkg::FRAME_WR_BIT] && state_reg == iofc_pkg::ST_RUN) begin
         case ({fa[6:1], 1'b0})
            iofc_pkg::ADDR_RATE_TRIM: begin
               if (fa[0]) rate_trim_next[15:8] = fd;
               else       rate_trim_next[7:0]  = fd;
            end
            iofc_pkg::ADDR_ACCX_TRIM, iofc_pkg::ADDR_ACCY_TRIM, iofc_pkg::ADDR_ACCZ_TRIM: begin
               for (int i = 0; i < 3; i++) begin
                  if ({fa[6:1], 1'b0} == iofc_pkg::ADDR_ACCX_TRIM + 7'(2 * i)) begin
                     if (fa[0]) acc_trim_next[i][15:8] = fd;
                     else       acc_trim_next[i][7:0]  = fd;
                  end
               end
            end
            iofc_pkg::ADDR_RANGE: begin
               if (fa[0]) range_next = fd[2:0];
            end
            iofc_pkg::ADDR_COMMAND: begin
               if (!fa[0] && fd[iofc_pkg::CMD_NULL_BIT]) begin
                  cmd_next[iofc_pkg::CMD_NULL_BIT] = 1'b1;
                  state_next = iofc_pkg::ST_NULL;
               end else if (!fa[0] && fd[iofc_pkg::CMD_PREC_BIT]) begin
                  cmd_next[iofc_pkg::CMD_PREC_BIT] = 1'b1;
                  state_next = iofc_pkg::ST_PREC;
                  timer_next = 30'(PREC_NULL_CYCLES - 1);
                  avg_next   = 18'sh00000;
                  off_next   = 1'b1;
               end
            end
            default: ;
         endcase
      end

      case (state_reg)
         iofc_pkg::ST_RUN: begin
            if (sample_valid) begin
               out14_next[0] = sat14(rng);
               for (int i = 0; i < 3; i++)
                  out14_next[i+1] = acc_res[i];
               pitch_next  = tilt(acc_res[0], pitch_align_reg);
               roll_next   = tilt(acc_res[1], roll_align_reg);
               supply_next = raw_supply;
               temp_next   = raw_temp;
               aux_next    = raw_aux;
               nd_next     = '1;
            end
         end
         iofc_pkg::ST_NULL: begin
            // New trim cancels the measured rate: trim - (raw + trim)
            rate_trim_next = {3'h0, sat13(18'(signed'(rate_trim_reg[12:0])) - fine)};
            state_next     = iofc_pkg::ST_SAVE;
            timer_next     = 30'(NV_SAVE_CYCLES - 1);
            save_next      = 1'b1;
         end
         iofc_pkg::ST_PREC: begin
            // Running average keeps the accumulator small over 30 s
            if (sample_valid)
               avg_next = avg_reg + ((fine - avg_reg) >>> iofc_pkg::AVG_SHIFT);
            if (timer_reg == 30'h0) begin
               rate_trim_next = {3'h0, sat13(18'(signed'(rate_trim_reg[12:0])) - avg_reg)};
               state_next     = iofc_pkg::ST_SAVE;
               timer_next     = 30'(NV_SAVE_CYCLES - 1);
               save_next      = 1'b1;
            end else begin
               timer_next = timer_reg - 30'h1;
            end
         end
         iofc_pkg::ST_SAVE: begin
            if (timer_reg == 30'h0) begin
               cmd_next   = 8'h00;
               off_next   = 1'b0;
               state_next = iofc_pkg::ST_RUN;
            end else begin
               timer_next = timer_reg - 30'h1;
            end
         end
         default: state_next = iofc_pkg::ST_RUN;
      endcase

      // Entering the save phase wipes all sensor data
      if (save_next) begin
         for (int i = 0; i < 4; i++)
            out14_next[i] = 14'h0000;
         pitch_next  = 13'h0000;
         roll_next   = 13'h0000;
         supply_next = 12'h000;
         temp_next   = 12'h000;
         aux_next    = 12'h000;
         nd_next     = 9'h000;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg       <= iofc_pkg::ST_RUN;
         for (int i = 0; i < 4; i++)
            out14_reg[i] <= 14'h0000;
         for (int i = 0; i < 3; i++)
            acc_trim_reg[i] <= iofc_pkg::TRIM_RESET;
         pitch_reg       <= 13'h0000;
         roll_reg        <= 13'h0000;
         supply_reg      <= 12'h000;
         temp_reg        <= 12'h000;
         aux_reg         <= 12'h000;
         nd_reg          <= 9'h000;
         rate_trim_reg   <= iofc_pkg::TRIM_RESET;
         pitch_align_reg <= PITCH_ALIGN_INIT;
         roll_align_reg  <= ROLL_ALIGN_INIT;
         range_reg       <= iofc_pkg::RANGE_WIDE;
         diag_reg        <= 16'h0000;
         cmd_reg         <= 8'h00;
         timer_reg       <= 30'h0;
         avg_reg         <= 18'sh00000;
         tx_reg          <= 16'h0000;
         save_reg        <= 1'b0;
         off_reg         <= 1'b0;
      end else if (ce) begin
         state_reg       <= state_next;
         out14_reg       <= out14_next;
         acc_trim_reg    <= acc_trim_next;
         pitch_reg       <= pitch_next;
         roll_reg        <= roll_next;
         supply_reg      <= supply_next;
         temp_reg        <= temp_next;
         aux_reg         <= aux_next;
         nd_reg          <= nd_next;
         rate_trim_reg   <= rate_trim_next;
         range_reg       <= range_next;
         diag_reg        <= diagnostic_status;
         cmd_reg         <= cmd_next;
         timer_reg       <= timer_next;
         avg_reg         <= avg_next;
         tx_reg          <= tx_next;
         save_reg        <= save_next;
         off_reg         <= off_next;
      end
   end

   assign fr.tx_word  = tx_reg;
   assign nv_save_req = save_reg;
   assign offline     = off_reg;
endmodule

// ### dv/iofc_host.sv
`timescale 1ns/1ns
module iofc_host (
   // Clock
   input  wire logic mclk,
   // Serial pins
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din  = 1'b0;
   end
   // -------------------------------------
   // Mode 3 frame, MSB first
   // -------------------------------------
   // Four mclk per half period, double the minimum, for margin
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      r = 16'h0000;
      @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (2) @(posedge mclk);
         sclk <= 1'b0;
         din  <= w[i];
         repeat (4) @(posedge mclk);
         r = {r[14:0], dout};
         sclk <= 1'b1;
         repeat (2) @(posedge mclk);
      end
      repeat (2) @(posedge mclk);
      cs_n <= 1'b1;
      din  <= ~din;
      repeat (6) @(posedge mclk);
   endtask
endmodule

// ### dv/iofc_core_chk.sv
`timescale 1ns/1ns
module iofc_core_chk #(
   parameter int NV_SAVE_CYCLES   = 20,
   parameter int PREC_NULL_CYCLES = 200
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Status
   input wire logic nv_save_req,
   input wire logic offline
);
   localparam int SAVE_MAX = 40;
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        saw_reg;
   logic        saw_next;
   always_comb begin
      cnt_next = offline ? cnt_reg + 32'h1 : 32'h0;
      saw_next = offline & (saw_reg | nv_save_req);
   end
   always_ff @(posedge mclk) begin
      cnt_reg <= rst ? 32'h0 : cnt_next;
      saw_reg <= rst ? 1'b0 : saw_next;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_release;
      ##[1:SAVE_MAX] !offline;
   endsequence
   a_save_single: assert property (nv_save_req |=> !nv_save_req) else $error("save pulse too long");
   a_reset_quiet: assert property ($fell(rst) |-> !nv_save_req && !offline) else $error("status after reset");
   a_offline_hold: assert property ($rose(offline) |=> offline[*8]) else $error("offline glitch");
   a_save_release: assert property (nv_save_req && offline |-> s_release) else $error("no release");
   a_prec_long: assert property (nv_save_req && offline |-> cnt_reg >= PREC_NULL_CYCLES - 1)
      else $error("null too short");
   a_offline_cap: assert property (offline |-> cnt_reg <= PREC_NULL_CYCLES + NV_SAVE_CYCLES + 8)
      else $error("offline too long");
   a_save_first: assert property ($fell(offline) |-> saw_reg) else $error("no save before end");
   a_end_late: assert property ($fell(offline) |-> cnt_reg >= PREC_NULL_CYCLES + NV_SAVE_CYCLES - 2)
      else $error("offline ended early");
endmodule
bind iofc_core iofc_core_chk #(.NV_SAVE_CYCLES(NV_SAVE_CYCLES), .PREC_NULL_CYCLES(PREC_NULL_CYCLES)) u_chk (
   .mclk(mclk), .rst(rst), .nv_save_req(nv_save_req), .offline(offline));

// ### dv/tb_iofc_core.sv
`timescale 1ns/1ns
module tb_iofc_core;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        sample_valid = 1'b0;
   logic [15:0] raw_rate = 16'h0000;
   logic [13:0] raw_acc = 14'h0010;
   logic [11:0] raw_misc = 12'h814;
   logic [15:0] diag = 16'h0000;
   logic        cs_n, sclk, din, dout, nv_save_req, offline;
   int          n_fail = 0;
   int          n_checks = 0;
   int          n_save = 0;
   int          cyc = 0;
   always #25 mclk = ~mclk;
   iofc_core #(.NV_SAVE_CYCLES(20), .PREC_NULL_CYCLES(200)) u_dut (.mclk(mclk), .rst(rst), .ce(1'b1),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .sample_valid(sample_valid), .raw_rate(raw_rate),
      .raw_accel_x(raw_acc), .raw_accel_y(raw_acc), .raw_accel_z(14'h2a84), .raw_supply(raw_misc),
      .raw_temp(raw_misc), .raw_aux(raw_misc), .diagnostic_status(diag), .nv_save_req(nv_save_req),
      .offline(offline));
   iofc_host u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
   always @(posedge mclk) begin
      cyc++;
      if (nv_save_req === 1'b1) n_save++;
      if (cyc == 30000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] w);
      logic [15:0] r;
      u_host.xfer(w, r);
   endtask
   // Second frame reads unmapped 0x00, so its answer is a harmless 0000
   task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] r;
      u_host.xfer({1'b0, a, 8'h00}, r);
      u_host.xfer(16'h0000, r);
      chk(r, exp);
   endtask
   task automatic smp(input logic [15:0] rr);
      @(posedge mclk);
      raw_rate     <= rr;
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
   endtask
   task automatic t_trims;
      rdc(iofc_pkg::ADDR_RATE_TRIM, 16'h0000);
      wr(16'h9b1f);
      wr(16'h9af6);
      wr(16'h9bff);
      rdc(iofc_pkg::ADDR_RATE_TRIM, 16'h1ff6);
      wr(16'ha1ff);
      wr(16'ha0a0);
      rdc(iofc_pkg::ADDR_ACCX_TRIM, 16'h0fa0);
      wr(16'h9d01);
      rdc(iofc_pkg::ADDR_PITCH_ALGN, 16'h0000);
      rdc(7'h40, 16'h0000);
   endtask
   task automatic t_sample;
      logic [6:0]  a[10] = '{7'h04, 7'h04, 7'h0a, 7'h0c, 7'h0e, 7'h12, 7'h14, 7'h02, 7'h10, 7'h16};
      logic [15:0] e[10] = '{16'h800a, 16'h000a, 16'hbfb0, 16'h8010, 16'haa84, 16'h9f9c, 16'h8014,
                             16'h8814, 16'h8814, 16'h8814};
      smp(16'd52);
      for (int i = 0; i < 10; i++) begin
         rdc(a[i], e[i]);
      end
      diag <= 16'h0004;
      smp(16'd52);
      rdc(iofc_pkg::ADDR_RATE, 16'hc00a);
      diag <= 16'h0000;
      wr(16'hb902);
      smp(16'd52);
      rdc(iofc_pkg::ADDR_RATE, 16'h8015);
      wr(16'hb901);
      smp(16'd52);
      rdc(iofc_pkg::ADDR_RATE, 16'h802a);
   endtask
   task automatic t_quick;
      wr(16'hbe01);
      repeat (40) @(posedge mclk);
      chk(16'(n_save), 16'h0001);
      rdc(iofc_pkg::ADDR_RATE_TRIM, 16'h1fcc);
      rdc(iofc_pkg::ADDR_RATE, 16'h0000);
      rdc(iofc_pkg::ADDR_COMMAND, 16'h0000);
   endtask
   task automatic t_prec;
      wr(16'hbe10);
      chk({15'h0000, offline}, 16'h0001);
      wr(16'h9b00);
      smp(16'd132);
      for (int i = 0; i < 400 && offline !== 1'b0; i++) @(posedge mclk);
      @(posedge mclk);
      chk({15'h0000, offline}, 16'h0000);
      chk(16'(n_save), 16'h0002);
      rdc(iofc_pkg::ADDR_RATE_TRIM, 16'h1fc7);
      rdc(iofc_pkg::ADDR_RATE, 16'h0000);
      rdc(iofc_pkg::ADDR_COMMAND, 16'h0000);
   endtask
   task automatic final_report;
      $display("Checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_trims();
      t_sample();
      t_quick();
      t_prec();
      final_report();
   end
endmodule
